// [src/rpf_defs.svh]
// Register map, field positions, reset values and timing constants.
`ifndef RPF_DEFS_SVH
`define RPF_DEFS_SVH
`define RPF_ADDR_CTRL 8'h04
`define RPF_ADDR_STAT 8'h06
`define RPF_ADDR_ED 8'h07
`define RPF_ADDR_SYNC 8'h15
`define RPF_CTRL_RST 8'h22
`define RPF_BIT_TXFCS 5
`define RPF_BIT_FCSOK 7
`define RPF_BIT_PDTDIS 7
`define RPF_RND_RST 2'h3
`define RPF_ED_RST 8'hFF
`define RPF_ED_MAX 13'h0053
`define RPF_RSSI_MAX 5'h1C
`define RPF_CLK_MHZ 200
`define RPF_RSSI_NS 2000
`define RPF_ED_LONG_NS 128000
`define RPF_ED_SHORT_NS 32000
`define RPF_ED_PROC_NS 4000
`define RPF_ED_VALID_NS 108000
`define RPF_READ_WIN_NS 224000
`define RPF_CYC(ns) (((ns) * `RPF_CLK_MHZ + 999) / 1000)
`define RPF_CYC_DN(ns) (((ns) * `RPF_CLK_MHZ) / 1000)
`define RPF_SHIFT_LONG 6
`define RPF_SHIFT_SHORT 4
`define RPF_H_TGT 3'h0
`define RPF_H_DATA 3'h1
`define RPF_H_GO 3'h2
`define RPF_H_STAT 3'h3
`define RPF_H_RDATA 3'h4
`define RPF_H_CFG 3'h5
`endif

// [src/rpf_pkg.sv]
// Types shared by both ends of the register link.
package rpf_pkg;
    typedef enum logic [1:0] {RX_OFF, RX_LISTEN, RX_BUSY} rpf_rx_t;
    typedef enum logic {M_IDLE, M_RUN} rpf_meas_t;
endpackage

// [src/rpf_link_if.sv]
// Register link between the host controller and the device.
`timescale 1ns/1ps
`default_nettype none
interface rpf_link_if;
    logic [7:0] regAddr;
    logic [7:0] regWdata;
    logic regWr;
    logic regRd;
    logic [7:0] regRdata;
    modport dev (input regAddr, input regWdata, input regWr,
                 input regRd, output regRdata);
    modport host (output regAddr, output regWdata, output regWr,
                  output regRd, input regRdata);
endinterface
`default_nettype wire

// [src/rpf_dev_end.sv]
// Device end: FCS control and status, strength field, energy detection.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "rpf_defs.svh"
module rpf_dev_end #(
    parameter int ED_LONG_CYC = `RPF_CYC(`RPF_ED_LONG_NS),
    parameter int ED_SHORT_CYC = `RPF_CYC(`RPF_ED_SHORT_NS),
    parameter int ED_PROC_CYC = `RPF_CYC(`RPF_ED_PROC_NS),
    parameter int ED_VALID_CYC = `RPF_CYC_DN(`RPF_ED_VALID_NS)
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    rpf_link_if.dev link,
    input wire rpf_pkg::rpf_rx_t rxState,
    input wire logic extMode,
    input wire logic highRate,
    input wire logic autoAckMode,
    input wire logic shrDetect,
    input wire logic frameDone,
    input wire logic fcsOk,
    input wire logic [4:0] rssiRaw,
    output logic txAutoFcs,
    output logic preambleDetectDisable,
    output logic frameStartIrq,
    output logic frameEndIrq,
    output logic measureDoneIrq
);
    import rpf_pkg::*;

    localparam int RSSI_CYC = `RPF_CYC(`RPF_RSSI_NS);
    localparam int FS_AT = ED_LONG_CYC + ED_PROC_CYC - ED_VALID_CYC;

    // Averaged strength in dB: sum of codes times three, divided by the
    // sample count, clipped to the top valid energy code.
    function automatic logic [7:0] edCode(input logic [10:0] sum,
                                          input logic shortWin);
        logic [12:0] db;
        db = 13'({2'h0, sum} * 13'h0003);
        db = shortWin ? (db >> `RPF_SHIFT_SHORT) : (db >> `RPF_SHIFT_LONG);
        if (db > `RPF_ED_MAX) begin
            db = `RPF_ED_MAX;
        end
        edCode = db[7:0];
    endfunction

    // ****************************************************************
    // Register write decode
    // ****************************************************************
    logic [7:0] ctrl_r;
    logic pdtDis_r;
    logic fcsValid_r;
    logic [4:0] rssi_r;
    logic [7:0] edLevel_r;
    logic [7:0] rdata_r;
    wire wrCtrl = link.regWr && (link.regAddr == `RPF_ADDR_CTRL);
    wire wrEd = link.regWr && (link.regAddr == `RPF_ADDR_ED);
    wire wrSync = link.regWr && (link.regAddr == `RPF_ADDR_SYNC);
    wire inRx = (rxState == RX_LISTEN) || (rxState == RX_BUSY);

    // The bit only steers the transmitter; no mode gates it.
    assign txAutoFcs = ctrl_r[`RPF_BIT_TXFCS];
    assign preambleDetectDisable = pdtDis_r;

    // Control registers written by the host.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r <= `RPF_CTRL_RST;
            pdtDis_r <= 1'b0;
        end else begin
            if (wrCtrl) begin
                ctrl_r <= link.regWdata;
            end
            if (wrSync) begin
                pdtDis_r <= link.regWdata[`RPF_BIT_PDTDIS];
            end
        end
    end

    // ****************************************************************
    // Frame check status
    // ****************************************************************
    // A bad frame in auto ack mode is dropped, so neither the flag nor
    // the interrupt moves.
    wire frameKept = frameDone && !(autoAckMode && !fcsOk);

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            fcsValid_r <= 1'b0;
            frameEndIrq <= 1'b0;
        end else begin
            frameEndIrq <= frameKept;
            if (frameKept) begin
                fcsValid_r <= fcsOk;
            end
        end
    end

    // ****************************************************************
    // Strength sampling
    // ****************************************************************
    logic [8:0] tickCnt_r;
    wire rssiTick = (tickCnt_r == 9'(RSSI_CYC - 1));
    // Raw codes above the top step are clipped; the analog front end
    // sets code zero at the base level, 3dB a step.
    wire [4:0] rssiClip = (rssiRaw > `RPF_RSSI_MAX) ? `RPF_RSSI_MAX
                                                    : rssiRaw;

    // The field is refreshed only while receiving in basic mode.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tickCnt_r <= 9'h000;
            rssi_r <= 5'h00;
        end else begin
            tickCnt_r <= rssiTick ? 9'h000 : tickCnt_r + 9'h001;
            if (rssiTick && inRx && !extMode) begin
                rssi_r <= rssiClip;
            end
        end
    end

    // ****************************************************************
    // Energy detection engine
    // ****************************************************************
    rpf_meas_t meas_r;
    logic [15:0] elapsed_r;
    logic [10:0] sum_r;
    logic isAuto_r;
    logic shortWin_r;
    logic irqOwed_r;
    logic autoLock_r;
    logic doneIrq_r;
    logic fsIrq_r;

    // SHR detection is masked by the preamble disable bit.
    wire autoStart = shrDetect && !pdtDis_r && inRx;
    // A request landing on the last cycle of a run starts the next one,
    // so it is never lost between the two.
    wire manStart = wrEd && inRx && ((meas_r == M_IDLE) || measEnd);
    wire [15:0] runLen = 16'((shortWin_r ? ED_SHORT_CYC : ED_LONG_CYC)
                             + ED_PROC_CYC);
    wire [15:0] sampLen = 16'(shortWin_r ? ED_SHORT_CYC : ED_LONG_CYC);
    wire measEnd = (meas_r == M_RUN) && (elapsed_r == runLen - 16'h0001);
    // A locked automatic result survives any manual request.
    wire storeOk = measEnd && (isAuto_r || !autoLock_r);
    // Outside receive the interrupt still comes, with no result.
    wire doneNow = (wrEd && !inRx) || (measEnd && irqOwed_r);

    assign measureDoneIrq = doneIrq_r;
    assign frameStartIrq = fsIrq_r;

    // Sequencer: an SHR seen in receive with the preamble disable bit clear
    // restarts the window as automatic, even mid-run; a
    // manual request during a run is answered at its end.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            meas_r <= M_IDLE;
            elapsed_r <= 16'h0000;
            sum_r <= 11'h000;
            isAuto_r <= 1'b0;
            shortWin_r <= 1'b0;
            irqOwed_r <= 1'b0;
        end else begin
            if (autoStart) begin
                meas_r <= M_RUN;
                elapsed_r <= 16'h0000;
                sum_r <= 11'h000;
                isAuto_r <= 1'b1;
                shortWin_r <= highRate;
                // A manual request that meets an SHR is still answered.
                irqOwed_r <= irqOwed_r || wrEd;
            end else if (manStart) begin
                meas_r <= M_RUN;
                elapsed_r <= 16'h0000;
                sum_r <= 11'h000;
                isAuto_r <= 1'b0;
                shortWin_r <= 1'b0;
                irqOwed_r <= 1'b1;
            end else if (meas_r == M_RUN) begin
                elapsed_r <= elapsed_r + 16'h0001;
                if (rssiTick && elapsed_r < sampLen) begin
                    sum_r <= sum_r + {6'h00, rssiClip};
                end
                if (wrEd && inRx) begin
                    irqOwed_r <= 1'b1;
                end
                if (measEnd) begin
                    meas_r <= M_IDLE;
                    irqOwed_r <= 1'b0;
                end
            end
        end
    end

    // Result store and frame lock. Writes never touch the value.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            edLevel_r <= `RPF_ED_RST;
            autoLock_r <= 1'b0;
            doneIrq_r <= 1'b0;
            fsIrq_r <= 1'b0;
        end else begin
            doneIrq_r <= doneNow;
            fsIrq_r <= (meas_r == M_RUN) && isAuto_r && !shortWin_r &&
                       (elapsed_r == 16'(FS_AT));
            if (storeOk) begin
                edLevel_r <= edCode(sum_r, shortWin_r);
            end
            if (measEnd && isAuto_r) begin
                autoLock_r <= 1'b1;
            end else if (frameDone || rxState != RX_BUSY || autoStart) begin
                autoLock_r <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    // Status word built from registers in one cycle.
    wire [7:0] statWord = {fcsValid_r, `RPF_RND_RST, rssi_r};
    wire [7:0] rdSel =
        (link.regAddr == `RPF_ADDR_CTRL) ? ctrl_r :
        (link.regAddr == `RPF_ADDR_STAT) ? statWord :
        (link.regAddr == `RPF_ADDR_ED) ? edLevel_r :
        (link.regAddr == `RPF_ADDR_SYNC) ? {pdtDis_r, 7'h00} : 8'h00;

    // Read data stand in the cycle after the strobe only.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= link.regRd ? rdSel : 8'h00;
        end
    end
    assign link.regRdata = rdata_r;
endmodule // rpf_dev_end
`default_nettype wire

// [src/rpf_host_end.sv]
// Host end: runs register accesses ordered through its own registers.
`timescale 1ns/1ps
`default_nettype none
`include "rpf_defs.svh"
module rpf_host_end #(
    parameter int READ_WIN_CYC = `RPF_CYC_DN(`RPF_READ_WIN_NS)
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    rpf_link_if.host link,
    input wire logic [2:0] usrAddr,
    input wire logic [7:0] usrWdata,
    input wire logic usrWr,
    input wire logic usrRd,
    output logic [7:0] usrRdata,
    input wire logic frameEndIrq
);
    import rpf_pkg::*;

    // ****************************************************************
    // Command registers
    // ****************************************************************
    logic [7:0] tgt_r;
    logic [7:0] data_r;
    logic [7:0] rbuf_r;
    logic extCfg_r;
    logic refused_r;
    logic late_r;
    logic lAddr_r;
    logic [7:0] linkAddr_r;
    logic [7:0] linkWdata_r;
    logic linkWr_r;
    logic linkRd_r;
    logic rdPend_r;
    logic [15:0] winCnt_r;
    logic winOpen_r;
    logic [7:0] usrRdata_r;

    wire busy = linkWr_r || linkRd_r || rdPend_r;
    wire goCmd = usrWr && (usrAddr == `RPF_H_GO) && !busy;
    wire goRead = usrWdata[0];
    // Extended mode bars strength reads and manual starts.
    wire bar = extCfg_r && (goRead ? (tgt_r == `RPF_ADDR_STAT)
                                   : (tgt_r == `RPF_ADDR_ED));
    wire issue = goCmd && !bar;
    // Energy read after the window since a frame end taken in extended mode is flagged.
    wire lateRd = issue && goRead && (tgt_r == `RPF_ADDR_ED) &&
                  !winOpen_r && lAddr_r;
    wire clrStat = usrWr && (usrAddr == `RPF_H_STAT);

    // Command and configuration registers; sticky flags, set wins.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tgt_r <= 8'h00;
            data_r <= 8'h00;
            extCfg_r <= 1'b0;
            refused_r <= 1'b0;
            late_r <= 1'b0;
        end else begin
            if (usrWr && usrAddr == `RPF_H_TGT) begin
                tgt_r <= usrWdata;
            end
            if (usrWr && usrAddr == `RPF_H_DATA) begin
                data_r <= usrWdata;
            end
            if (usrWr && usrAddr == `RPF_H_CFG) begin
                extCfg_r <= usrWdata[0];
            end
            refused_r <= (goCmd && bar) ||
                         (refused_r && !(clrStat && usrWdata[1]));
            late_r <= lateRd || (late_r && !(clrStat && usrWdata[2]));
        end
    end

    // ****************************************************************
    // Link sequencer
    // ****************************************************************
    // Strobes last one cycle; read data are caught the cycle after.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            linkAddr_r <= 8'h00;
            linkWdata_r <= 8'h00;
            linkWr_r <= 1'b0;
            linkRd_r <= 1'b0;
            rdPend_r <= 1'b0;
            rbuf_r <= 8'h00;
        end else begin
            linkWr_r <= issue && !goRead;
            linkRd_r <= issue && goRead;
            rdPend_r <= linkRd_r;
            if (issue) begin
                linkAddr_r <= tgt_r;
                linkWdata_r <= data_r;
            end
            if (rdPend_r) begin
                rbuf_r <= link.regRdata;
            end
        end
    end
    assign link.regAddr = linkAddr_r;
    assign link.regWdata = linkWdata_r;
    assign link.regWr = linkWr_r;
    assign link.regRd = linkRd_r;

    // Read window opened by each frame end; a new SHR may overwrite
    // the energy value once it closes.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            winCnt_r <= 16'h0000;
            winOpen_r <= 1'b0;
            lAddr_r <= 1'b0;
        end else begin
            if (frameEndIrq) begin
                winCnt_r <= 16'h0000;
                winOpen_r <= 1'b1;
                lAddr_r <= extCfg_r;
            end else if (winOpen_r) begin
                winCnt_r <= winCnt_r + 16'h0001;
                winOpen_r <= (winCnt_r != 16'(READ_WIN_CYC - 1));
            end
        end
    end

    // ****************************************************************
    // User read port
    // ****************************************************************
    wire [7:0] uSel =
        (usrAddr == `RPF_H_TGT) ? tgt_r :
        (usrAddr == `RPF_H_DATA) ? data_r :
        (usrAddr == `RPF_H_STAT) ? {5'h00, late_r, refused_r, busy} :
        (usrAddr == `RPF_H_RDATA) ? rbuf_r :
        (usrAddr == `RPF_H_CFG) ? {7'h00, extCfg_r} : 8'h00;

    // Data stand one cycle after the read strobe only.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            usrRdata_r <= 8'h00;
        end else begin
            usrRdata_r <= usrRd ? uSel : 8'h00;
        end
    end
    assign usrRdata = usrRdata_r;
endmodule // rpf_host_end
`default_nettype wire

// [tb/rpf_link_monitor.sv]
// Checker for the register link between the host end and the device end.
`timescale 1ns/1ps
`default_nettype none
module rpf_link_monitor (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdata
);
    // ********************
    // Helper state
    // ********************
    logic rdPend_r;
    logic [7:0] rdAddr_r;
    logic [7:0] ctrlShadow_r;
    // Decodes of the read answered in this cycle.
    wire logic rdCtrl = rdPend_r && (rdAddr_r == 8'h04);
    wire logic rdStat = rdPend_r && (rdAddr_r == 8'h06);
    wire logic rdEd = rdPend_r && (rdAddr_r == 8'h07);
    wire logic rdSync = rdPend_r && (rdAddr_r == 8'h15);
    wire logic rdOther = rdPend_r && !(rdCtrl || rdStat || rdEd || rdSync);
    // A shadow of the control register lets a read-back be judged exactly.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdPend_r <= 1'b0;
            rdAddr_r <= 8'h00;
            ctrlShadow_r <= 8'h22;
        end else begin
            rdPend_r <= regRd;
            rdAddr_r <= regAddr;
            if (regWr && (regAddr == 8'h04)) begin
                ctrlShadow_r <= regWdata;
            end
        end
    end
    // ********************
    // Assertions
    // ********************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    a_no_dual_strobe: assert property (!(regWr && regRd))
        else $error("read and write strobes high together");
    a_idle_rdata_zero: assert property (!rdPend_r |-> regRdata == 8'h00)
        else $error("read data not zero outside its cycle");
    a_unmapped_zero: assert property (rdOther |-> regRdata == 8'h00)
        else $error("unmapped read returned nonzero data");
    a_ed_code_range: assert property (
        rdEd |-> (regRdata <= 8'h53) || (regRdata == 8'hFF))
        else $error("energy code outside its legal set");
    a_stat_fixed_bits: assert property (rdStat |-> regRdata[6:5] == 2'b11)
        else $error("status random bits not constant");
    a_strength_range: assert property (rdStat |-> regRdata[4:0] <= 5'h1C)
        else $error("strength code above its maximum");
    a_ctrl_readback: assert property (rdCtrl |-> regRdata == ctrlShadow_r)
        else $error("control register read-back differs");
    a_wr_single: assert property (regWr |=> !regWr)
        else $error("write strobe longer than one cycle");
    a_rd_single: assert property (regRd |=> !regRd && rdPend_r)
        else $error("read strobe longer than one cycle");
endmodule // rpf_link_monitor
`default_nettype wire

// [tb/rx_power_and_fcs_status_tb.sv]
// Testbench joining the host end and the device end over the register link.
`timescale 1ns/1ps
`default_nettype none
module rx_power_and_fcs_status_tb;
    import rpf_pkg::*;
    // ********************
    // Stimulus and wiring
    // ********************
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    rpf_rx_t rxState = RX_OFF;
    logic extMode = 1'b0, highRate = 1'b0, autoAckMode = 1'b0;
    logic shrDetect = 1'b0, frameDone = 1'b0, fcsOk = 1'b0;
    logic [4:0] rssiRaw = 5'h00;
    logic [2:0] usrAddr = 3'h0;
    logic [7:0] usrWdata = 8'h00;
    logic usrWr = 1'b0, usrRd = 1'b0;
    logic [7:0] usrRdata, v;
    logic txAutoFcs, pdd, frameStartIrq, frameEndIrq, measureDoneIrq;
    int miscompares = 0, checks = 0, cycles = 0, n;
    rpf_link_if link();
    rpf_dev_end #(.ED_LONG_CYC(64), .ED_SHORT_CYC(16), .ED_PROC_CYC(4),
        .ED_VALID_CYC(60)) u_rpf_dev_end (.ref_clk(ref_clk), .rst_b(rst_b),
        .link(link), .rxState(rxState), .extMode(extMode),
        .highRate(highRate), .autoAckMode(autoAckMode),
        .shrDetect(shrDetect), .frameDone(frameDone), .fcsOk(fcsOk),
        .rssiRaw(rssiRaw), .txAutoFcs(txAutoFcs),
        .preambleDetectDisable(pdd), .frameStartIrq(frameStartIrq),
        .frameEndIrq(frameEndIrq), .measureDoneIrq(measureDoneIrq));
    rpf_host_end #(.READ_WIN_CYC(50)) u_rpf_host_end (.ref_clk(ref_clk),
        .rst_b(rst_b), .link(link), .usrAddr(usrAddr), .usrWdata(usrWdata),
        .usrWr(usrWr), .usrRd(usrRd), .usrRdata(usrRdata),
        .frameEndIrq(frameEndIrq));
    rpf_link_monitor u_rpf_link_monitor (.ref_clk(ref_clk), .rst_b(rst_b),
        .regAddr(link.regAddr), .regWdata(link.regWdata),
        .regWr(link.regWr), .regRd(link.regRd), .regRdata(link.regRdata));
    // Free-running clock and a ceiling on the run length.
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            summarize();
        end
    end
    // ********************
    // Shared tasks
    // ********************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic uw(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        usrAddr <= a;
        usrWdata <= d;
        usrWr <= 1'b1;
        @(posedge ref_clk);
        usrWr <= 1'b0;
    endtask
    task automatic ur(input logic [2:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        usrAddr <= a;
        usrRd <= 1'b1;
        @(posedge ref_clk);
        usrRd <= 1'b0;
        // The data stand for one cycle; take them at the edge that ends it,
        // before that edge updates the port.
        @(posedge ref_clk);
        d = usrRdata;
    endtask
    // Device register write and read carried out by the host end.
    task automatic dwr(input logic [7:0] a, input logic [7:0] d);
        uw(3'h0, a);
        uw(3'h1, d);
        uw(3'h2, 8'h00);
    endtask
    task automatic drd(input logic [7:0] a, output logic [7:0] d);
        uw(3'h0, a);
        uw(3'h2, 8'h01);
        repeat (3) @(posedge ref_clk);
        ur(3'h4, d);
    endtask
    // Counts edges until an interrupt pulse; 200 means none came.
    task automatic waitFor(input bit md, output int c);
        c = 0;
        do begin
            @(posedge ref_clk);
            c++;
        end while (((md ? measureDoneIrq : frameStartIrq) !== 1'b1)
                   && c < 200);
    endtask
    task automatic frame(input logic ok, input logic [7:0] irq);
        @(posedge ref_clk);
        frameDone <= 1'b1;
        fcsOk <= ok;
        @(posedge ref_clk);
        frameDone <= 1'b0;
        @(posedge ref_clk);
        chk({7'h00, frameEndIrq}, irq);
    endtask
    // ********************
    // Scenarios
    // ********************
    task automatic t_reset();
        chk({7'h00, txAutoFcs}, 8'h01);
        drd(8'h04, v);
        chk(v, 8'h22);
        drd(8'h06, v);
        chk(v, 8'h60);
        drd(8'h07, v);
        chk(v, 8'hFF);
        drd(8'h30, v);
        chk(v, 8'h00);
    endtask
    task automatic t_ctrl();
        dwr(8'h04, 8'h02);
        repeat (2) @(posedge ref_clk);
        chk({7'h00, txAutoFcs}, 8'h00);
        extMode <= 1'b1;
        dwr(8'h04, 8'h22);
        repeat (2) @(posedge ref_clk);
        chk({7'h00, txAutoFcs}, 8'h01);
        extMode <= 1'b0;
        dwr(8'h06, 8'h00);
        drd(8'h06, v);
        chk(v, 8'h60);
    endtask
    task automatic t_fcs();
        frame(1'b1, 8'h01);
        fcsOk <= 1'b0;
        drd(8'h06, v);
        chk({7'h00, v[7]}, 8'h01);
        autoAckMode <= 1'b1;
        frame(1'b0, 8'h00);
        drd(8'h06, v);
        chk({7'h00, v[7]}, 8'h01);
        autoAckMode <= 1'b0;
        frame(1'b0, 8'h01);
        drd(8'h06, v);
        chk({7'h00, v[7]}, 8'h00);
    endtask
    task automatic t_rssi();
        rxState <= RX_LISTEN;
        rssiRaw <= 5'h1F;
        repeat (401) @(posedge ref_clk);
        drd(8'h06, v);
        chk({3'h0, v[4:0]}, 8'h1C);
        extMode <= 1'b1;
        rssiRaw <= 5'h05;
        repeat (401) @(posedge ref_clk);
        drd(8'h06, v);
        chk({3'h0, v[4:0]}, 8'h1C);
        extMode <= 1'b0;
        repeat (401) @(posedge ref_clk);
        drd(8'h06, v);
        chk({3'h0, v[4:0]}, 8'h05);
        rssiRaw <= 5'h00;
    endtask
    task automatic t_off();
        rxState <= RX_OFF;
        dwr(8'h07, 8'h33);
        waitFor(1'b1, n);
        chk(8'(n <= 3), 8'h01);
        drd(8'h07, v);
        chk(v, 8'hFF);
    endtask
    task automatic t_auto();
        rxState <= RX_BUSY;
        dwr(8'h15, 8'h80);
        @(posedge ref_clk) shrDetect <= 1'b1;
        @(posedge ref_clk) shrDetect <= 1'b0;
        chk({7'h00, pdd}, 8'h01);
        waitFor(1'b0, n);
        chk(8'(n == 200), 8'h01);
        dwr(8'h15, 8'h00);
        @(posedge ref_clk) shrDetect <= 1'b1;
        @(posedge ref_clk) shrDetect <= 1'b0;
        waitFor(1'b0, n);
        // Strobe at 64 + 4 - 60 = 8 counts into the run, seen two edges on.
        chk(8'(n), 8'h0A);
        waitFor(1'b1, n);
        chk(8'(n == 200), 8'h01);
        drd(8'h07, v);
        chk(v, 8'h00);
        dwr(8'h07, 8'h00);
        waitFor(1'b1, n);
        chk(8'(n < 200), 8'h01);
    endtask
    task automatic t_manual();
        rxState <= RX_LISTEN;
        frame(1'b1, 8'h01);
        dwr(8'h07, 8'h5A);
        waitFor(1'b1, n);
        chk(8'(n >= 68 && n <= 72), 8'h01);
        drd(8'h07, v);
        chk(v, 8'h00);
    endtask
    task automatic t_host();
        uw(3'h5, 8'h01);
        dwr(8'h07, 8'h00);
        ur(3'h3, v);
        chk(v, 8'h02);
        uw(3'h3, 8'h06);
        drd(8'h06, v);
        ur(3'h3, v);
        chk(v, 8'h02);
        uw(3'h3, 8'h06);
        frame(1'b1, 8'h01);
        drd(8'h07, v);
        ur(3'h3, v);
        chk(v, 8'h00);
        frame(1'b1, 8'h01);
        repeat (60) @(posedge ref_clk);
        drd(8'h07, v);
        ur(3'h3, v);
        chk(v, 8'h04);
        uw(3'h5, 8'h00);
    endtask
    // Main sequence: reset for ten cycles, then every scenario in turn.
    initial begin
        repeat (10) @(posedge ref_clk);
        rst_b <= 1'b1;
        t_reset();
        t_ctrl();
        t_fcs();
        t_rssi();
        t_off();
        t_auto();
        t_manual();
        t_host();
        summarize();
    end
endmodule // rx_power_and_fcs_status_tb
`default_nettype wire
